/* File: hdl/mcuio_pkg.sv */
// Constants and carrier types for the port pin control block
package mcuio_pkg;
    // Bidirectional ports in index order 0,1,6,7,8
    localparam int NPORT = 5;
    localparam logic [2:0] P0_IDX = 3'h0;
    localparam logic [2:0] P1_IDX = 3'h1;
    localparam logic [2:0] P7_IDX = 3'h3;
    localparam logic [2:0] P8_IDX = 3'h4;
    // Implemented bits per bidirectional port
    localparam logic [4:0][7:0] BIDIR_MASK =
        {8'hFF, 8'h03, 8'hFF, 8'h1F, 8'h47};
    // Register map, byte addresses on an 8-bit APB address
    localparam logic [3:0] PORT_BLOCKS = 4'h5;
    localparam logic [3:0] OFS_OUT = 4'h0;
    localparam logic [3:0] OFS_DIR = 4'h4;
    localparam logic [3:0] OFS_PULL = 4'h8;
    localparam logic [3:0] OFS_PSEL = 4'hC;
    localparam logic [7:0] ADR_P2_IN = 8'h50;
    localparam logic [7:0] ADR_P2_PULL = 8'h54;
    localparam logic [7:0] ADR_PA_IN = 8'h58;
    localparam logic [7:0] ADR_PA_PULL = 8'h5C;
    localparam logic [7:0] ADR_PA_PSEL = 8'h60;
    localparam logic [7:0] ADR_P1_FSEL = 8'h64;
    localparam logic [7:0] ADR_SER_MODE3 = 8'h68;
    localparam logic [7:0] ADR_MISC = 8'h6C;
    localparam logic [7:0] ADR_RST_CTRL = 8'h70;
    // Serial mode register 3 fields
    localparam int SM_TX = 0;
    localparam int SM_RX = 1;
    localparam int SM_CLK = 2;
    localparam int SM_TX_OD = 3;
    localparam int SM_CLK_OD = 4;
    // Misc register fields
    localparam int MS_BUZZ = 0;
    localparam int MS_ZCROSS = 1;
    // Reset values
    localparam logic [7:0] LAT_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] PULL_RST = 8'h00;
    localparam logic [4:0] FSEL_RST = 5'h00;
    localparam logic [4:0] SMR_RST = 5'h00;
    localparam logic [1:0] MISC_RST = 2'h0;
    localparam logic RSTBIT_RST = 1'b1;
    // Clock settling wait after reset release
    localparam int CLK_PERIOD_NS = 40;
    localparam int STAB_TIME_NS = 100000;
    localparam int STAB_CYCLES =
        (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] STAB_LAST = 12'(STAB_CYCLES - 1);
    // Pad drive bundle of one 8-bit port
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
        logic [7:0] pu;
        logic [7:0] pd;
    } mcuio_pad_t;
endpackage

/* File: hdl/mcuio_sync.sv */
// Two-stage synchroniser for pin levels
`timescale 1ns/10ps
module mcuio_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_ff; // First stage, read only by second
    logic [W-1:0] sync_ff; // Second stage, safe to use
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    // Shift the pin level through both stages
    always_comb begin
        nxt_meta = i_async;
        nxt_sync = meta_ff;
    end

    // Stages clear to zero under reset
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign o_sync = sync_ff;
endmodule

/* File: hdl/mcuio_pin.sv */
// Output stage of one bidirectional pin with function mux
`timescale 1ns/10ps
module mcuio_pin (
    input wire logic i_lat,
    input wire logic i_dir,
    input wire logic i_fn_en,
    input wire logic i_fn_val,
    input wire logic i_od,
    output logic o_o,
    output logic o_oe
);
    logic val; // Level the pin should show

    // Special function overrides the latch only when selected
    always_comb begin
        val = i_fn_en ? i_fn_val : i_lat;
        // Open-drain drives only lows, so a high floats
        o_oe = i_dir & (~i_od | ~val);
        o_o = i_od ? 1'b0 : val;
    end
endmodule

/* File: hdl/mcuio_top.sv */
// Port pin control: registers, pin muxing and reset pin
`timescale 1ns/10ps
module mcuio_top (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic [4:0][7:0] I_PORT_PIN,
    output mcuio_pkg::mcuio_pad_t [4:0] O_PORT_PAD,
    input wire logic [3:0] I_P2_PIN,
    output logic [3:0] O_P2_PU,
    input wire logic [7:0] I_PA_PIN,
    output logic [7:0] O_PA_PU,
    output logic [7:0] O_PA_PD,
    input wire logic I_RST_PIN_N,
    output logic O_RST_PIN_O,
    output logic O_RST_PIN_OE,
    output logic O_SW_RESET,
    output logic O_RESET_IRQ,
    input wire logic I_SER_TX,
    output logic O_SER_RX,
    input wire logic I_SER_CLK,
    output logic O_SER_CLK_IN,
    input wire logic I_REMOTE_CARRIER,
    input wire logic [2:0] I_TMR_OUT,
    output logic [2:0] O_TMR_IN,
    input wire logic I_BUZZER,
    output logic [3:0] O_EXT_IRQ,
    output logic O_ZERO_CROSS,
    output logic [7:0] O_ANALOG_CH,
    output logic [7:0] O_LED_DRIVE
);
    localparam int SYNC_W = 53; // Bidir 40, port A 8, port 2 4, reset 1

    // Register state
    logic [4:0][7:0] lat_ff, nxt_lat;   // Output latches
    logic [4:0][7:0] dir_ff, nxt_dir;   // 1 = output
    logic [4:0][7:0] pul_ff, nxt_pul;   // Pull enables
    logic p7sel_ff, nxt_p7sel;          // 1 = port 7 pulls down
    logic [3:0] p2pu_ff, nxt_p2pu;      // Port 2 pull-ups
    logic [7:0] papu_ff, nxt_papu;      // Port A pull enables
    logic pasel_ff, nxt_pasel;          // 1 = port A pulls down
    logic [4:0] fsel_ff, nxt_fsel;      // Port 1 output function
    logic [4:0] smr_ff, nxt_smr;        // Serial mode register 3
    logic [1:0] misc_ff, nxt_misc;      // Buzzer, zero-cross
    logic rstb_ff, nxt_rstb;            // Reset pin port bit latch
    // Bus answer state
    logic [31:0] prdata_ff, nxt_prdata;
    logic err_ff, nxt_err;
    // Clock settling state
    logic [11:0] stab_ff, nxt_stab;
    logic done_ff, nxt_done;
    logic irq_ff, nxt_irq;

    // Synchronised pin levels
    logic [SYNC_W-1:0] sync_in, sync_out;
    logic [4:0][7:0] pin_s;
    logic [3:0] p2_s;
    logic [7:0] pa_s;
    logic rstpin_s;

    // Decode helpers
    logic [2:0] pidx;
    logic [3:0] sub;
    logic hit;
    logic wr_en;
    logic [7:0] rd8;
    logic [7:0] wd8;

    // Function mux into the pin cells
    logic [4:0][7:0] fn_en, fn_val, od;

    assign sync_in = {I_RST_PIN_N, I_PA_PIN, I_P2_PIN, I_PORT_PIN};

    // Every pin passes two flops before any logic sees it
    mcuio_sync #(.W(SYNC_W)) u_sync (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_async(sync_in),
        .o_sync(sync_out)
    );

    assign pin_s = sync_out[39:0];
    assign p2_s = sync_out[43:40];
    assign pa_s = sync_out[51:44];
    assign rstpin_s = sync_out[52];

    assign pidx = I_PADDR[6:4];
    assign sub = I_PADDR[3:0];
    assign wd8 = I_PWDATA[7:0];
    // Writes land only at the access edge of a good transfer
    assign wr_en = I_PSEL & I_PENABLE & I_PWRITE & hit;

    // Address decode and read value
    always_comb begin
        hit = 1'b0;
        rd8 = 8'h00;
        if (I_PADDR[7:4] < mcuio_pkg::PORT_BLOCKS) begin
            hit = 1'b1;
            case (sub)
                mcuio_pkg::OFS_OUT:
                    // Pin level for inputs, latch for outputs
                    rd8 = mcuio_pkg::BIDIR_MASK[pidx] &
                        ((dir_ff[pidx] & lat_ff[pidx]) |
                         (~dir_ff[pidx] & pin_s[pidx]));
                mcuio_pkg::OFS_DIR: rd8 = dir_ff[pidx];
                mcuio_pkg::OFS_PULL: rd8 = pul_ff[pidx];
                mcuio_pkg::OFS_PSEL: begin
                    // Pull direction exists on port 7 only
                    hit = (pidx == mcuio_pkg::P7_IDX);
                    rd8 = {7'h00, p7sel_ff & hit};
                end
                default: hit = 1'b0;
            endcase
        end else begin
            hit = 1'b1;
            case (I_PADDR)
                mcuio_pkg::ADR_P2_IN: rd8 = {4'h0, p2_s};
                mcuio_pkg::ADR_P2_PULL: rd8 = {4'h0, p2pu_ff};
                mcuio_pkg::ADR_PA_IN: rd8 = pa_s;
                mcuio_pkg::ADR_PA_PULL: rd8 = papu_ff;
                mcuio_pkg::ADR_PA_PSEL: rd8 = {7'h00, pasel_ff};
                mcuio_pkg::ADR_P1_FSEL: rd8 = {3'h0, fsel_ff};
                mcuio_pkg::ADR_SER_MODE3: rd8 = {3'h0, smr_ff};
                mcuio_pkg::ADR_MISC: rd8 = {6'h00, misc_ff};
                // Latch, pin level, clock settled
                mcuio_pkg::ADR_RST_CTRL:
                    rd8 = {5'h00, done_ff, rstpin_s, rstb_ff};
                default: hit = 1'b0;
            endcase
        end
    end

    // Register next values; unused port bits never stick
    always_comb begin
        nxt_lat = lat_ff;
        nxt_dir = dir_ff;
        nxt_pul = pul_ff;
        nxt_p7sel = p7sel_ff;
        nxt_p2pu = p2pu_ff;
        nxt_papu = papu_ff;
        nxt_pasel = pasel_ff;
        nxt_fsel = fsel_ff;
        nxt_smr = smr_ff;
        nxt_misc = misc_ff;
        nxt_rstb = rstb_ff;
        if (wr_en && I_PADDR[7:4] < mcuio_pkg::PORT_BLOCKS) begin
            case (sub)
                // Per-bit latch, direction and pull
                mcuio_pkg::OFS_OUT:
                    nxt_lat[pidx] = wd8 & mcuio_pkg::BIDIR_MASK[pidx];
                mcuio_pkg::OFS_DIR:
                    nxt_dir[pidx] = wd8 & mcuio_pkg::BIDIR_MASK[pidx];
                mcuio_pkg::OFS_PULL:
                    nxt_pul[pidx] = wd8 & mcuio_pkg::BIDIR_MASK[pidx];
                // One direction bit for the port: no mixing
                mcuio_pkg::OFS_PSEL: nxt_p7sel = wd8[0];
                default: nxt_p7sel = p7sel_ff;
            endcase
        end else if (wr_en) begin
            case (I_PADDR)
                mcuio_pkg::ADR_P2_PULL: nxt_p2pu = wd8[3:0];
                mcuio_pkg::ADR_PA_PULL: nxt_papu = wd8;
                mcuio_pkg::ADR_PA_PSEL: nxt_pasel = wd8[0];
                mcuio_pkg::ADR_P1_FSEL: nxt_fsel = wd8[4:0];
                mcuio_pkg::ADR_SER_MODE3: nxt_smr = wd8[4:0];
                mcuio_pkg::ADR_MISC: nxt_misc = wd8[1:0];
                // Writing 0 starts a software reset
                mcuio_pkg::ADR_RST_CTRL: nxt_rstb = wd8[0];
                default: nxt_rstb = rstb_ff;
            endcase
        end
    end

    // Everything resets to inputs with pulls off
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            lat_ff <= {5{mcuio_pkg::LAT_RST}};
            dir_ff <= {5{mcuio_pkg::DIR_RST}};
            pul_ff <= {5{mcuio_pkg::PULL_RST}};
            p7sel_ff <= 1'b0;
            p2pu_ff <= mcuio_pkg::PULL_RST[3:0];
            papu_ff <= mcuio_pkg::PULL_RST;
            pasel_ff <= 1'b0;
            fsel_ff <= mcuio_pkg::FSEL_RST;
            smr_ff <= mcuio_pkg::SMR_RST;
            misc_ff <= mcuio_pkg::MISC_RST;
            rstb_ff <= mcuio_pkg::RSTBIT_RST;
        end else begin
            lat_ff <= nxt_lat;
            dir_ff <= nxt_dir;
            pul_ff <= nxt_pul;
            p7sel_ff <= nxt_p7sel;
            p2pu_ff <= nxt_p2pu;
            papu_ff <= nxt_papu;
            pasel_ff <= nxt_pasel;
            fsel_ff <= nxt_fsel;
            smr_ff <= nxt_smr;
            misc_ff <= nxt_misc;
            rstb_ff <= nxt_rstb;
        end
    end

    // Read data and error caught in the setup cycle
    always_comb begin
        nxt_prdata = prdata_ff;
        nxt_err = err_ff;
        if (I_PSEL && !I_PENABLE) begin
            nxt_prdata = {24'h000000, rd8};
            nxt_err = ~hit;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            prdata_ff <= 32'h00000000;
            err_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            err_ff <= nxt_err;
        end
    end

    // No wait states: every access phase completes at once
    assign O_PREADY = I_PSEL & I_PENABLE;
    assign O_PSLVERR = O_PREADY & err_ff;
    assign O_PRDATA = prdata_ff;

    // Wait for the clock to settle, then raise reset interrupt
    always_comb begin
        nxt_stab = stab_ff;
        nxt_done = done_ff;
        nxt_irq = 1'b0;
        if (!done_ff) begin
            if (stab_ff == mcuio_pkg::STAB_LAST) begin
                nxt_done = 1'b1;
                nxt_irq = 1'b1;
            end else begin
                nxt_stab = stab_ff + 12'h001;
            end
        end
    end

    // Reset pin low holds this at zero via the chip reset
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            stab_ff <= 12'h000;
            done_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            stab_ff <= nxt_stab;
            done_ff <= nxt_done;
            irq_ff <= nxt_irq;
        end
    end

    assign O_RESET_IRQ = irq_ff;

    // Open-drain reset pin: low only, never driven high
    assign O_RST_PIN_O = 1'b0;
    assign O_RST_PIN_OE = ~rstb_ff;
    assign O_SW_RESET = ~rstb_ff;

    // Special function selection per pin
    always_comb begin
        fn_en = '0;
        fn_val = '0;
        od = '0;
        // Serial tx and clock only with output and mode set
        fn_en[0][0] = dir_ff[0][0] & smr_ff[mcuio_pkg::SM_TX];
        fn_val[0][0] = I_SER_TX;
        od[0][0] = fn_en[0][0] & smr_ff[mcuio_pkg::SM_TX_OD];
        fn_en[0][2] = dir_ff[0][2] & smr_ff[mcuio_pkg::SM_CLK];
        fn_val[0][2] = I_SER_CLK;
        od[0][2] = fn_en[0][2] & smr_ff[mcuio_pkg::SM_CLK_OD];
        fn_en[0][6] = dir_ff[0][6] & misc_ff[mcuio_pkg::MS_BUZZ];
        fn_val[0][6] = I_BUZZER;
        // Carrier and timers need select and output
        fn_en[1][0] = dir_ff[1][0] & fsel_ff[0];
        fn_val[1][0] = I_REMOTE_CARRIER;
        for (int t = 0; t < 3; t++) begin
            fn_en[1][t+2] = dir_ff[1][t+2] & fsel_ff[t+2];
            fn_val[1][t+2] = I_TMR_OUT[t];
        end
    end

    // One pin cell per port bit; masked bits stay undriven
    for (genvar p = 0; p < mcuio_pkg::NPORT; p++) begin : g_port
        for (genvar b = 0; b < 8; b++) begin : g_bit
            mcuio_pin u_pin (
                .i_lat(lat_ff[p][b]),
                .i_dir(dir_ff[p][b] & mcuio_pkg::BIDIR_MASK[p][b]),
                .i_fn_en(fn_en[p][b]),
                .i_fn_val(fn_val[p][b]),
                .i_od(od[p][b]),
                .o_o(O_PORT_PAD[p].o[b]),
                .o_oe(O_PORT_PAD[p].oe[b])
            );
        end
        // Pull-up, or pull-down on port 7 by its port-wide select
        if (p == 3) begin : g_ud
            assign O_PORT_PAD[p].pu = pul_ff[p] & {8{~p7sel_ff}};
            assign O_PORT_PAD[p].pd = pul_ff[p] & {8{p7sel_ff}};
        end else begin : g_up
            assign O_PORT_PAD[p].pu = pul_ff[p];
            assign O_PORT_PAD[p].pd = 8'h00;
        end
    end

    assign O_P2_PU = p2pu_ff;
    assign O_PA_PU = papu_ff & {8{~pasel_ff}};
    assign O_PA_PD = papu_ff & {8{pasel_ff}};

    // Inputs to peripherals; serial inputs idle high when not selected, timer inputs and zero-cross idle low
    assign O_SER_RX = (~dir_ff[0][1] & smr_ff[mcuio_pkg::SM_RX]) ?
        pin_s[0][1] : 1'b1;
    assign O_SER_CLK_IN = (~dir_ff[0][2] & smr_ff[mcuio_pkg::SM_CLK]) ?
        pin_s[0][2] : 1'b1;
    assign O_TMR_IN = pin_s[1][4:2] & ~dir_ff[1][4:2];
    assign O_EXT_IRQ = p2_s;
    assign O_ZERO_CROSS = misc_ff[mcuio_pkg::MS_ZCROSS] & p2_s[1];
    assign O_ANALOG_CH = pa_s;
    // LED lines are the bits of port 8 driven low
    assign O_LED_DRIVE = O_PORT_PAD[4].oe & ~O_PORT_PAD[4].o;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    reset_state_a: assert property ($past(I_RESET) |->
        dir_ff == '0 && pul_ff == '0 && p2pu_ff == 4'h0 && rstb_ff)
        else $error("port state not cleared by reset");
    p0_dir_write_a: assert property (
        wr_en && I_PADDR == {4'h0, mcuio_pkg::OFS_DIR} |=>
        dir_ff[0] == ($past(I_PWDATA[7:0]) & 8'h47))
        else $error("port 0 direction write lost");
    p1_pull_write_a: assert property (
        wr_en && I_PADDR == {4'h1, mcuio_pkg::OFS_PULL} |=>
        O_PORT_PAD[1].pu == ($past(I_PWDATA[7:0]) & 8'h1F))
        else $error("port 1 pull-up write lost");
    sw_reset_pin_a: assert property (
        wr_en && I_PADDR == mcuio_pkg::ADR_RST_CTRL && !I_PWDATA[0]
        |=> O_RST_PIN_OE && !O_RST_PIN_O && O_SW_RESET)
        else $error("software reset did not pull pin low");
    reset_irq_a: assert property (
        $rose(done_ff) |-> O_RESET_IRQ ##1 !O_RESET_IRQ[*8])
        else $error("reset interrupt not a single pulse");
    p7_no_mix_a: assert property (
        (O_PORT_PAD[3].pu & O_PORT_PAD[3].pd) == 8'h00)
        else $error("port 7 pulls mixed");
    tx_mux_a: assert property (
        dir_ff[0][0] && smr_ff[0] && !smr_ff[3] |->
        O_PORT_PAD[0].oe[0] && O_PORT_PAD[0].o[0] == I_SER_TX)
        else $error("serial tx not on port 0 bit 0");
    timer_out_a: assert property (
        !dir_ff[1][2] |-> !O_PORT_PAD[1].oe[2])
        else $error("timer pin driven while input");
    read_latch_a: assert property (
        I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == 8'h20 &&
        dir_ff[2] == 8'hFF |=> O_PRDATA[7:0] == $past(lat_ff[2]))
        else $error("output port read not the latch");

    sw_reset_c: cover property (!rstb_ff ##1 O_RST_PIN_OE);
    tx_path_c: cover property (fn_en[0][0] && I_SER_TX);
    err_c: cover property (O_PSLVERR);
endmodule

/* File: sim/mcuio_board.sv */
// Board model: outside drivers and pull resistors on the port pins
`timescale 1ns/10ps
module mcuio_board (
    input wire logic i_clk,
    input mcuio_pkg::mcuio_pad_t [4:0] i_pad,
    input wire logic [4:0][7:0] i_ext,
    input wire logic [4:0][7:0] i_ext_en,
    output logic [4:0][7:0] o_pin
);
    // Pattern for a floating pin, so no stale level can pass for data
    logic flip_ff = 1'b0;
    always @(posedge i_clk) begin
        flip_ff <= ~flip_ff;
    end
    // Device drive wins, then board driver, then pulls
    always_comb begin
        for (int p = 0; p < 5; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (i_pad[p].oe[b]) o_pin[p][b] = i_pad[p].o[b];
                else if (i_ext_en[p][b]) o_pin[p][b] = i_ext[p][b];
                else if (i_pad[p].pu[b]) o_pin[p][b] = 1'b1;
                else if (i_pad[p].pd[b]) o_pin[p][b] = 1'b0;
                else o_pin[p][b] = flip_ff ^ b[0];
            end
        end
    end
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the port pin control block
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0, rst = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0][7:0] ext = '0, ext_en = '0, pin;
    mcuio_pkg::mcuio_pad_t [4:0] pad;
    logic [3:0] p2 = 4'h0, p2_pu, irq;
    logic [7:0] pa = 8'h00, pa_pu, pa_pd, an, led, e, msk, oe_e;
    logic rst_oe, rst_o, sw_rst, rst_irq, rx, sclk_in, zc;
    logic stx = 1'b0, sclk = 1'b0, car = 1'b0, buzz = 1'b0;
    logic [2:0] tmr = 3'h0, tmr_in;
    // Behavioural model of latch, direction and pull per port
    logic [7:0] m_lat [5], m_dir [5], m_pul [5];
    integer seed = 32'h9C83;
    int err_total = 0, checked = 0;
    always #20 clk = ~clk;
    mcuio_top dut (.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_PORT_PIN(pin), .O_PORT_PAD(pad),
        .I_P2_PIN(p2), .O_P2_PU(p2_pu), .I_PA_PIN(pa), .O_PA_PU(pa_pu),
        .O_PA_PD(pa_pd), .I_RST_PIN_N(~rst_oe), .O_RST_PIN_O(rst_o),
        .O_RST_PIN_OE(rst_oe), .O_SW_RESET(sw_rst),
        .O_RESET_IRQ(rst_irq), .I_SER_TX(stx), .O_SER_RX(rx),
        .I_SER_CLK(sclk), .O_SER_CLK_IN(sclk_in),
        .I_REMOTE_CARRIER(car), .I_TMR_OUT(tmr), .O_TMR_IN(tmr_in),
        .I_BUZZER(buzz), .O_EXT_IRQ(irq), .O_ZERO_CROSS(zc),
        .O_ANALOG_CH(an), .O_LED_DRIVE(led));
    mcuio_board brd (.i_clk(clk), .i_pad(pad), .i_ext(ext),
        .i_ext_en(ext_en), .o_pin(pin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d, checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            err_total++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
    endtask
    // Pins need two synchroniser flops before they show
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Port read and pad drive against the model
    task automatic port_chk(input int p);
        logic [7:0] cm, ev;
        cm = m_dir[p] | ext_en[p] | m_pul[p];
        ev = (m_dir[p] & m_lat[p]) | (~m_dir[p] & ext_en[p] & ext[p])
            | (~m_dir[p] & ~ext_en[p] & m_pul[p]);
        apb(1'b0, 8'(p * 16), 32'h0);
        chk(rd & cm, ev & cm & mcuio_pkg::BIDIR_MASK[p]);
        chk(pad[p].oe, m_dir[p]);
        chk(pad[p].pu & msk, m_pul[p]);
        chk(pad[p].o & pad[p].oe, m_lat[p] & m_dir[p]);
    endtask
    initial begin
        int p, n, v, od;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Clock settle wait ends in a single reset interrupt pulse
        for (n = 1; n <= 3000; n++) begin
            @(posedge clk);
            #1;
            if (rst_irq === 1'b1) break;
        end
        chk(n, mcuio_pkg::STAB_CYCLES);
        cyc(1);
        chk(rst_irq, 1'b0);
        for (p = 0; p < 5; p++) begin
            rc(8'(p * 16 + 4), 32'h0);
            rc(8'(p * 16 + 8), 32'h0);
            chk(pad[p].oe | pad[p].pu | pad[p].pd, 32'h0);
        end
        rc(mcuio_pkg::ADR_P2_PULL, 32'h0);
        rc(mcuio_pkg::ADR_PA_PULL, 32'h0);
        // Random direction, pull, latch and board drive per port
        repeat (4) begin
            for (p = 0; p < 5; p++) begin
                msk = mcuio_pkg::BIDIR_MASK[p];
                m_lat[p] = 8'($random(seed));
                m_dir[p] = 8'($random(seed)) & msk;
                m_pul[p] = 8'($random(seed)) & msk;
                ext[p] <= 8'($random(seed));
                ext_en[p] <= 8'($random(seed));
                wr(8'(p * 16), m_lat[p]);
                wr(8'(p * 16 + 4), m_dir[p]);
                wr(8'(p * 16 + 8), m_pul[p]);
                cyc(3);
                port_chk(p);
            end
            chk(led, m_dir[4] & ~m_lat[4]);
        end
        // Port 7 pulls switched to pull-down as a whole
        wr(8'h3C, 8'h01);
        cyc(1);
        chk({pad[3].pd, pad[3].pu}, {m_pul[3], 8'h00});
        // All-output port 6 reads back its latch
        wr(8'h24, 8'hFF);
        rc(8'h20, {24'h0, m_lat[2]});
        // Peripheral outputs: serial, buzzer, carrier, timers
        ext_en <= '1;
        wr(8'h04, 8'h45);
        wr(mcuio_pkg::ADR_MISC, 8'h01);
        wr(8'h14, 8'h15);
        wr(mcuio_pkg::ADR_P1_FSEL, 8'h1D);
        for (od = 0; od < 2; od++) begin
            wr(mcuio_pkg::ADR_SER_MODE3, od ? 8'h1D : 8'h05);
            for (v = 0; v < 2; v++) begin
                {stx, sclk, buzz, car} <= {4{v[0]}};
                tmr <= {3{v[0]}};
                cyc(1);
                oe_e = 8'h40 | ((od && v) ? 8'h00 : 8'h05);
                chk({pad[0].oe & 8'h45, pad[0].o & pad[0].oe & 8'h45},
                    {oe_e, v ? oe_e : 8'h00});
                chk({pad[1].oe & 8'h1F, pad[1].o & 8'h15},
                    {8'h15, v ? 8'h15 : 8'h00});
            end
        end
        cyc(3);
        chk(tmr_in, {1'b0, ext[1][3], 1'b0});
        wr(mcuio_pkg::ADR_SER_MODE3, 8'h02);
        cyc(3);
        chk(rx, ext[0][1]);
        wr(8'h04, 8'h00);
        wr(mcuio_pkg::ADR_SER_MODE3, 8'h05);
        cyc(3);
        chk(pad[0].oe[0], 1'b0);
        chk(rx, 1'b1);
        chk(sclk_in, ext[0][2]);
        wr(mcuio_pkg::ADR_SER_MODE3, 8'h01);
        cyc(1);
        chk(sclk_in, 1'b1);
        // Input-only ports, interrupt and analog routing
        repeat (3) begin
            p2 <= 4'($random(seed));
            pa <= 8'($random(seed));
            e = 8'($random(seed));
            wr(mcuio_pkg::ADR_P2_PULL, e);
            wr(mcuio_pkg::ADR_PA_PULL, e);
            wr(mcuio_pkg::ADR_PA_PSEL, {7'h00, e[0]});
            wr(mcuio_pkg::ADR_MISC, 8'h02);
            cyc(3);
            chk({irq, zc}, {p2, p2[1]});
            chk(an, pa);
            chk(p2_pu, e[3:0]);
            chk({pa_pu, pa_pd}, e[0] ? {8'h00, e} : {e, 8'h00});
            rc(mcuio_pkg::ADR_P2_IN, p2);
            rc(mcuio_pkg::ADR_PA_IN, pa);
        end
        // Unmapped address is refused
        apb(1'b0, 8'h74, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        // Software reset drives the pin low until a hardware reset
        wr(mcuio_pkg::ADR_RST_CTRL, 8'h00);
        cyc(3);
        chk({sw_rst, rst_oe, rst_o}, 3'h6);
        rc(mcuio_pkg::ADR_RST_CTRL, 32'h4);
        // Mid-run reset, driven on clock edges like the bus signals
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        chk({sw_rst, rst_oe, pad[0].oe, pad[4].oe}, 18'h0);
        rc(8'h44, 32'h0);
        summarize();
    end
endmodule
